// ### conv_flags_cfg.svh
// register offsets, field positions and timing counts for the converter event flags
`ifndef CONV_FLAGS_CFG_SVH
`define CONV_FLAGS_CFG_SVH
`define OFS_PAIR_A_FLAGS   8'h19
`define OFS_PAIR_B_FLAGS   8'h1a
`define OFS_PAIR_A_LIVE    8'h1c
`define OFS_PAIR_B_LIVE    8'h1d
`define FLAGS_RESET        8'h00
`define BIT_ODD_GOOD       6
`define BIT_ODD_SHORT      5
`define BIT_ODD_CURLIM     4
`define BIT_EVEN_GOOD      2
`define BIT_EVEN_SHORT     1
`define BIT_EVEN_CURLIM    0
`define FLAG_MASK          8'h77
`define CLK_PERIOD_NS      4
`define RISE_TIMEOUT_MS    1
`define RISE_TIMEOUT_CYC   ((`RISE_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// ### conv_flags_pkg.sv
// types shared by the converter event flag block
package conv_flags_pkg;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_RISING,
    ST_RUNNING
  } conv_state_t;
endpackage

// ### conv_monitor.sv
// per-converter monitor: synchronises detector levels, raises a one-cycle power-good event; short (while running) and current-limit events follow their levels
`timescale 1ns/10ps
`default_nettype none
`include "conv_flags_cfg.svh"
module conv_monitor
  import conv_flags_pkg::*;
#(
  parameter int unsigned RISE_TIMEOUT = `RISE_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset,
  // raw analog detector levels
  input  wire logic i_enabled,
  input  wire logic i_power_good,
  input  wire logic i_above_short,
  input  wire logic i_curlimit,
  // events and live status
  output logic      o_good_evt,
  output logic      o_short_evt,
  output logic      o_curlimit_evt,
  output logic      o_curlimit_live,
  output logic      o_goodvolt_live
);
  logic [3:0]  meta_reg;
  logic [3:0]  sync_reg;
  logic        good_prev_reg;
  logic [31:0] timer_reg;
  conv_state_t state_reg;
  conv_state_t state_next;

  wire en_s    = sync_reg[0];
  wire good_s  = sync_reg[1];
  wire above_s = sync_reg[2];
  wire ilim_s  = sync_reg[3];
  // timer parks at the limit, one past the reporting count, so a stuck start-up is reported only once
  wire timed_out = (timer_reg >= RISE_TIMEOUT);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:     if (en_s) state_next = ST_RISING;
      ST_RISING: begin
        if (!en_s) state_next = ST_OFF;
        else if (above_s) state_next = ST_RUNNING;
      end
      ST_RUNNING: if (!en_s) state_next = ST_OFF;
      default:    state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      meta_reg      <= 4'h0;
      sync_reg      <= 4'h0;
      good_prev_reg <= 1'b0;
      timer_reg     <= 32'h0000_0000;
      state_reg     <= ST_OFF;
    end else begin
      meta_reg      <= {i_curlimit, i_above_short, i_power_good, i_enabled};
      sync_reg      <= meta_reg;
      good_prev_reg <= good_s;
      state_reg     <= state_next;
      timer_reg     <= (state_reg == ST_RISING && !timed_out) ? timer_reg + 32'h0000_0001
                       : (state_reg == ST_RISING ? timer_reg : 32'h0000_0000);
    end
  end

  assign o_good_evt = good_s && !good_prev_reg;
  // drop while running; start-up timeout reported once
  assign o_short_evt = (state_reg == ST_RUNNING && en_s && !above_s)
                     || (state_reg == ST_RISING && timer_reg == RISE_TIMEOUT - 1 && !above_s);
  assign o_curlimit_evt  = ilim_s;
  assign o_curlimit_live = ilim_s;
  assign o_goodvolt_live = good_s;

  // the start-up timeout is a single event, even while the output stays low
  sequence rise_expiring;
    state_reg == ST_RISING && timer_reg == RISE_TIMEOUT - 1;
  endsequence
  sequence rise_quiet;
    !(state_reg == ST_RISING && o_short_evt);
  endsequence
  chk_timeout_once: assert property (@(posedge i_mclk) disable iff (i_reset)
    rise_expiring |=> rise_quiet)
    else $error("start-up timeout reported twice");
endmodule
`default_nettype wire

// ### buck_fault_flag_latches.sv
// latched converter event flags with write-1-to-clear register access
`timescale 1ns/10ps
`default_nettype none
`include "conv_flags_cfg.svh"
module buck_fault_flag_latches
  import conv_flags_pkg::*;
#(
  parameter int unsigned RISE_TIMEOUT = `RISE_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // register port from the serial interface
  input  wire logic       i_reg_wr,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // analog detector levels, one bit per converter
  input  wire logic [3:0] i_conv_enabled,
  input  wire logic [3:0] i_conv_power_good,
  input  wire logic [3:0] i_conv_above_short,
  input  wire logic [3:0] i_conv_curlimit,
  // summary and live status
  output logic      [3:0] o_summary_pending,
  output logic      [3:0] o_curlimit_live,
  output logic      [3:0] o_goodvolt_live
);
  logic [7:0] pair_a_reg;
  logic [7:0] pair_b_reg;
  logic [7:0] pair_a_next;
  logic [7:0] pair_b_next;
  logic [7:0] rdata_reg;
  logic [3:0] good_evt;
  logic [3:0] short_evt;
  logic [3:0] cl_evt;
  logic [3:0] cl_live;
  logic [3:0] gv_live;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_conv
      conv_monitor #(.RISE_TIMEOUT(RISE_TIMEOUT)) u_mon (
        .i_mclk          (i_mclk),
        .i_reset         (i_reset),
        .i_enabled       (i_conv_enabled[g]),
        .i_power_good    (i_conv_power_good[g]),
        .i_above_short   (i_conv_above_short[g]),
        .i_curlimit      (i_conv_curlimit[g]),
        .o_good_evt      (good_evt[g]),
        .o_short_evt     (short_evt[g]),
        .o_curlimit_evt  (cl_evt[g]),
        .o_curlimit_live (cl_live[g]),
        .o_goodvolt_live (gv_live[g])
      );
    end
  endgenerate

  // pack two converters' events into register layout
  function automatic logic [7:0] pack_evt(input logic [1:0] gd, input logic [1:0] sc,
                                          input logic [1:0] cl);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_ODD_GOOD]    = gd[1];
    v[`BIT_ODD_SHORT]   = sc[1];
    v[`BIT_ODD_CURLIM]  = cl[1];
    v[`BIT_EVEN_GOOD]   = gd[0];
    v[`BIT_EVEN_SHORT]  = sc[0];
    v[`BIT_EVEN_CURLIM] = cl[0];
    return v;
  endfunction

  wire [7:0] set_a = pack_evt(good_evt[1:0], short_evt[1:0], cl_evt[1:0]);
  wire [7:0] set_b = pack_evt(good_evt[3:2], short_evt[3:2], cl_evt[3:2]);
  wire       wr_a  = i_reg_wr && (i_reg_addr == `OFS_PAIR_A_FLAGS);
  wire       wr_b  = i_reg_wr && (i_reg_addr == `OFS_PAIR_B_FLAGS);
  wire [7:0] clr_a = wr_a ? i_reg_wdata : 8'h00;
  wire [7:0] clr_b = wr_b ? i_reg_wdata : 8'h00;

  // write one clears; zero keeps, reserved forced low; set wins over clear
  assign pair_a_next = ((pair_a_reg & ~clr_a) | set_a) & `FLAG_MASK;
  assign pair_b_next = ((pair_b_reg & ~clr_b) | set_b) & `FLAG_MASK;

  wire [7:0] live_a = {1'b0, gv_live[1], 1'b0, cl_live[1], 1'b0, gv_live[0], 1'b0, cl_live[0]};
  wire [7:0] live_b = {1'b0, gv_live[3], 1'b0, cl_live[3], 1'b0, gv_live[2], 1'b0, cl_live[2]};
  wire [7:0] rd_mux = (i_reg_addr == `OFS_PAIR_A_FLAGS) ? pair_a_reg :
                      (i_reg_addr == `OFS_PAIR_B_FLAGS) ? pair_b_reg :
                      (i_reg_addr == `OFS_PAIR_A_LIVE)  ? live_a :
                      (i_reg_addr == `OFS_PAIR_B_LIVE)  ? live_b : 8'h00;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pair_a_reg <= `FLAGS_RESET;
      pair_b_reg <= `FLAGS_RESET;
      rdata_reg  <= 8'h00;
    end else begin
      pair_a_reg <= pair_a_next;
      pair_b_reg <= pair_b_next;
      rdata_reg  <= rd_mux;
    end
  end

  assign o_reg_rdata = rdata_reg;
  // summary follows any flag of that converter
  assign o_summary_pending = {|pair_b_reg[6:4], |pair_b_reg[2:0],
                              |pair_a_reg[6:4], |pair_a_reg[2:0]};
  assign o_curlimit_live = cl_live;
  assign o_goodvolt_live = gv_live;

  // set wins over a clear that lands in the same cycle
  chk_set_wins_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (set_a != 8'h00) |=> ((pair_a_reg & $past(set_a)) == $past(set_a)))
    else $error("pair a event lost");
  chk_set_wins_b: assert property (@(posedge i_mclk) disable iff (i_reset)
    (set_b != 8'h00) |=> ((pair_b_reg & $past(set_b)) == $past(set_b)))
    else $error("pair b event lost");
  chk_clear_drops_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_a && set_a == 8'h00) |=> ((pair_a_reg & $past(i_reg_wdata)) == 8'h00))
    else $error("pair a flag not cleared");
  chk_clear_drops_b: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_b && set_b == 8'h00) |=> ((pair_b_reg & $past(i_reg_wdata)) == 8'h00))
    else $error("pair b flag not cleared");
  chk_zero_keeps_a: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_a && i_reg_wdata == 8'h00) |=> ((pair_a_reg & $past(pair_a_reg)) == $past(pair_a_reg)))
    else $error("zero write changed flag");
  chk_zero_keeps_b: assert property (@(posedge i_mclk) disable iff (i_reset)
    (wr_b && i_reg_wdata == 8'h00) |=> ((pair_b_reg & $past(pair_b_reg)) == $past(pair_b_reg)))
    else $error("zero write changed flag");
  // a write to any other address must leave both registers alone
  chk_other_addr: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_reg_wr && !wr_a && !wr_b && set_a == 8'h00 && set_b == 8'h00)
    |=> (pair_a_reg == $past(pair_a_reg) && pair_b_reg == $past(pair_b_reg)))
    else $error("foreign write changed flags");
  chk_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_reset)
    ((pair_a_reg | pair_b_reg) & ~`FLAG_MASK) == 8'h00)
    else $error("reserved bit set");
  chk_summary_tracks: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_summary_pending[3] == (pair_b_reg[6:4] != 3'b000))
    else $error("summary mismatch");
  chk_short_sets: assert property (@(posedge i_mclk) disable iff (i_reset)
    short_evt[0] |=> pair_a_reg[`BIT_EVEN_SHORT])
    else $error("short flag not set");
  chk_curlim_sets: assert property (@(posedge i_mclk) disable iff (i_reset)
    cl_evt[3] |=> pair_b_reg[`BIT_ODD_CURLIM])
    else $error("current limit flag not set");
  chk_good_sets: assert property (@(posedge i_mclk) disable iff (i_reset)
    good_evt[1] |=> pair_a_reg[`BIT_ODD_GOOD])
    else $error("good flag not set");
  chk_read_flags: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_reg_addr == `OFS_PAIR_A_FLAGS) |=> (o_reg_rdata == $past(pair_a_reg)))
    else $error("read data wrong");
  chk_read_flags_b: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_reg_addr == `OFS_PAIR_B_FLAGS) |=> (o_reg_rdata == $past(pair_b_reg)))
    else $error("pair b read data wrong");
  chk_read_live: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_reg_addr == `OFS_PAIR_B_LIVE) |=> (o_reg_rdata[`BIT_EVEN_CURLIM] == $past(cl_live[2])))
    else $error("live status read wrong");

  // per-converter view of the latched flags: pair register, bit positions, write strobe
  generate
    for (g = 0; g < 4; g++) begin : g_chk
      localparam int POS_GOOD  = (g % 2 == 1) ? `BIT_ODD_GOOD : `BIT_EVEN_GOOD;
      localparam int POS_SHORT = (g % 2 == 1) ? `BIT_ODD_SHORT : `BIT_EVEN_SHORT;
      localparam int POS_CURL  = (g % 2 == 1) ? `BIT_ODD_CURLIM : `BIT_EVEN_CURLIM;
      wire [7:0] pair_view = (g < 2) ? pair_a_reg : pair_b_reg;
      wire       pair_wr   = (g < 2) ? wr_a : wr_b;
      wire       good_bit  = pair_view[POS_GOOD];
      wire       short_bit = pair_view[POS_SHORT];
      wire       curl_bit  = pair_view[POS_CURL];
      wire       good_clr  = pair_wr && i_reg_wdata[POS_GOOD];
      wire       short_clr = pair_wr && i_reg_wdata[POS_SHORT];
      wire       curl_clr  = pair_wr && i_reg_wdata[POS_CURL];

      // a one written while no event arrives in that cycle
      sequence good_dropped;
        good_clr && !good_evt[g];
      endsequence
      sequence short_dropped;
        short_clr && !short_evt[g];
      endsequence
      sequence curl_dropped;
        curl_clr && !cl_evt[g];
      endsequence

      chk_good_latched: assert property (@(posedge i_mclk) disable iff (i_reset)
        good_evt[g] |=> good_bit)
        else $error("power good flag not latched");
      chk_good_sticky: assert property (@(posedge i_mclk) disable iff (i_reset)
        (good_bit && !good_clr) |=> good_bit)
        else $error("power good flag dropped");
      chk_good_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
        good_dropped |=> !good_bit)
        else $error("power good flag not cleared");
      chk_short_latched: assert property (@(posedge i_mclk) disable iff (i_reset)
        short_evt[g] |=> short_bit)
        else $error("short flag not latched");
      chk_short_sticky: assert property (@(posedge i_mclk) disable iff (i_reset)
        (short_bit && !short_clr) |=> short_bit)
        else $error("short flag dropped");
      chk_short_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
        short_dropped |=> !short_bit)
        else $error("short flag not cleared");
      chk_curlim_latched: assert property (@(posedge i_mclk) disable iff (i_reset)
        cl_evt[g] |=> curl_bit)
        else $error("current limit flag not latched");
      chk_curlim_sticky: assert property (@(posedge i_mclk) disable iff (i_reset)
        (curl_bit && !curl_clr) |=> curl_bit)
        else $error("current limit flag dropped");
      chk_curlim_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
        curl_dropped |=> !curl_bit)
        else $error("current limit flag not cleared");
      chk_summary_conv: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_summary_pending[g] == (good_bit || short_bit || curl_bit))
        else $error("converter summary mismatch");
    end
  endgenerate
endmodule
`default_nettype wire

// ### conv_plant.sv
// behavioural converter outputs seen by the detectors
`timescale 1ns/10ps
`default_nettype none
module conv_plant (
  // clock and commands
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_enable,
  input  wire logic [3:0] i_stuck,
  input  wire logic [3:0] i_short,
  input  wire logic [3:0] i_limit,
  // detector levels
  output logic      [3:0] o_good,
  output logic      [3:0] o_above,
  output logic      [3:0] o_curlimit
);
  logic [3:0] ramp1_reg = 4'h0;
  logic [3:0] ramp2_reg = 4'h0;
  // output ramps over two cycles; a stuck core never rises
  // rising edge, so commands applied on the falling edge are never raced
  always_ff @(posedge i_mclk) begin
    ramp1_reg <= i_enable & ~i_stuck;
    ramp2_reg <= ramp1_reg & i_enable & ~i_stuck;
  end
  assign o_above    = ramp2_reg & ~i_short;
  assign o_good     = o_above;
  assign o_curlimit = i_limit & i_enable;
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the converter event flags
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       i_mclk = 0, i_reset = 1, i_reg_wr = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic [3:0] en = 0, stuck = 0, shrt = 0, lim = 0;
  logic [3:0] good, above, curl, summ, cl_live, gv_live;
  int         failures = 0, comparisons = 0;

  buck_fault_flag_latches #(.RISE_TIMEOUT(20)) i_dut (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_conv_enabled(en), .i_conv_power_good(good),
    .i_conv_above_short(above), .i_conv_curlimit(curl), .o_summary_pending(summ),
    .o_curlimit_live(cl_live), .o_goodvolt_live(gv_live));
  conv_plant i_plant (.i_mclk(i_mclk), .i_enable(en), .i_stuck(stuck), .i_short(shrt),
    .i_limit(lim), .o_good(good), .o_above(above), .o_curlimit(curl));

  initial begin
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_mclk);
    i_reg_wr = 1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_mclk);
    i_reg_wr = 0;
  endtask
  // read data follows the address by one cycle
  task automatic rd(string name, logic [7:0] a, logic [7:0] m, logic [7:0] exp);
    @(negedge i_mclk);
    i_reg_addr = a;
    @(negedge i_mclk);
    check(name, exp, o_reg_rdata & m);
  endtask
  task automatic t_good();
    en = 4'hf;
    idle(8);
    rd("good_a", 8'h19, 8'hff, 8'h44);
    rd("good_b", 8'h1a, 8'hff, 8'h44);
    rd("good_live_reg", 8'h1c, 8'hff, 8'h44);
    check("summary", 8'h0f, {4'h0, summ});
    check("good_live", 8'h0f, {4'h0, gv_live});
  endtask
  task automatic t_clear();
    wr(8'h19, 8'h00);
    rd("zero_keeps", 8'h19, 8'hff, 8'h44);
    wr(8'h1b, 8'hff);
    rd("other_addr", 8'h1a, 8'hff, 8'h44);
    wr(8'h19, 8'h04);
    rd("clear_one", 8'h19, 8'hff, 8'h40);
    check("summary", 8'h0e, {4'h0, summ});
    wr(8'h19, 8'hff);
    wr(8'h1a, 8'hff);
    rd("clear_all", 8'h1a, 8'hff, 8'h00);
    check("summary", 8'h00, {4'h0, summ});
  endtask
  task automatic t_short();
    shrt = 4'h2;
    idle(4);
    shrt = 4'h0;
    idle(6);
    // recovery raises power good again
    rd("short_run", 8'h19, 8'hff, 8'h60);
    wr(8'h19, 8'hff);
  endtask
  task automatic t_limit();
    lim = 4'h4;
    idle(4);
    check("limit_live", 8'h04, {4'h0, cl_live});
    rd("limit_flag", 8'h1a, 8'hff, 8'h01);
    rd("limit_live_reg", 8'h1d, 8'hff, 8'h45);
    wr(8'h1a, 8'h01);
    rd("limit_held", 8'h1a, 8'hff, 8'h01);
    lim = 4'h0;
    idle(4);
    wr(8'h1a, 8'h01);
    rd("limit_clr", 8'h1a, 8'hff, 8'h00);
  endtask
  task automatic t_timeout();
    en = 4'h0;
    stuck = 4'h8;
    idle(6);
    wr(8'h19, 8'hff);
    wr(8'h1a, 8'hff);
    en = 4'h8;
    idle(12);
    rd("rise_early", 8'h1a, 8'h70, 8'h00);
    idle(12);
    rd("rise_late", 8'h1a, 8'h70, 8'h20);
    wr(8'h1a, 8'h20);
    rd("rise_once", 8'h1a, 8'h70, 8'h00);
  endtask
  // reset in mid-run with a flag standing
  task automatic t_reset();
    lim = 4'h8;
    idle(4);
    rd("limit_pre_reset", 8'h1a, 8'hff, 8'h10);
    i_reset = 1;
    idle(4);
    lim = 4'h0;
    i_reset = 0;
    rd("reset_mid", 8'h1a, 8'hff, 8'h00);
    check("summary_reset", 8'h00, {4'h0, summ});
  endtask
  task automatic print_verdict();
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    i_reset = 0;
    rd("reset_a", 8'h19, 8'hff, 8'h00);
    rd("reset_b", 8'h1a, 8'hff, 8'h00);
    t_good();
    t_clear();
    t_short();
    t_limit();
    t_timeout();
    t_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
